// ### hdl/cts_addr_gen.sv
// Operand address former for the direct, extended, indexed and stack-offset encodings.
`timescale 1ns/1ps

module cts_addr_gen
	import cts_pkg::*;
(
	input  wire cts_mode_type mode,
	input  wire logic [7:0]   hiByte,
	input  wire logic [7:0]   loByte,
	input  wire logic [15:0]  index,
	input  wire logic [15:0]  stackPtr,
	output logic [15:0]       addr
);

	// ****************************************************************
	// Address forming
	// ****************************************************************

	// Offsets are unsigned; sums wrap in 16 bits like the program counter does.
	always_comb begin
		case (mode)
			MODE_DIR: addr = {8'h00, loByte};
			MODE_ABS: addr = {hiByte, loByte}; // RULE9
			MODE_XP:  addr = index; // RULE7
			MODE_XB:  addr = index + {8'h00, loByte}; // RULE6
			MODE_XW:  addr = index + {hiByte, loByte}; // RULE10
			MODE_SB:  addr = stackPtr + {8'h00, loByte}; // RULE5
			default:  addr = index;
		endcase
	end

endmodule

// ### hdl/cts_core.sv
// Core sequencer for the test, transfer, trap and wait instructions with its register port.
//
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps

module cts_core
	import cts_pkg::*;
#(
	parameter logic [15:0] TRAP_VECTOR = 16'hFFF0,
	parameter logic [15:0] IRQ_VECTOR  = 16'hFFF2,
	parameter logic [15:0] RESET_PC    = 16'h0000,
	parameter logic [15:0] RESET_SP    = 16'h00FF
)
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        irqReq,
	input  wire logic [7:0]  memRdata,
	output logic [15:0]      memAddr,
	output logic [7:0]       memWdata,
	output logic             memRead,
	output logic             memWrite,
	output logic             clockStop,
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic [31:0]      readdata,
	output logic             waitrequest
);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************

	// Each vector needs two bytes below the top of the address space.
	if (TRAP_VECTOR == 16'hFFFF || IRQ_VECTOR == 16'hFFFF) begin : gBadVector
		$error("Vector addresses must leave room for a low byte.");
	end

	// ****************************************************************
	// Functions
	// ****************************************************************

	// Flags after a comparison against zero: N and Z follow, V clears.
	function automatic logic [7:0] testFlags(input logic [7:0] flags, input logic [7:0] val);
		logic [7:0] res;
		res = flags;
		res[FLAG_N] = val[7];
		res[FLAG_Z] = (val == 8'h00);
		res[FLAG_V] = 1'b0;
		return res;
	endfunction

	// Byte pushed at each step of the stacking sequence.
	function automatic logic [7:0] pushByte(input logic [2:0] idx, input logic [15:0] pc,
			input logic [7:0] xl, input logic [7:0] a, input logic [7:0] flags);
		case (idx)
			3'h0:    pushByte = pc[7:0];
			3'h1:    pushByte = pc[15:8];
			3'h2:    pushByte = xl;
			3'h3:    pushByte = a;
			default: pushByte = flags;
		endcase
	endfunction

	// Merges the enabled low byte lanes of a bus write into a 16-bit value.
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		merge16 = old;
		if (be[0]) begin
			merge16[7:0] = wd[7:0];
		end
		if (be[1]) begin
			merge16[15:8] = wd[15:8];
		end
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	cts_core_type r;
	cts_core_type next_r;
	logic [15:0]  opAddr;
	logic [15:0]  pcInc;
	logic [15:0]  vecBase;
	logic [31:0]  regValue;
	logic         cpuIdle;

	// Operand address from the captured mode, the saved high byte and the byte on the bus.
	cts_addr_gen uAddrGen (
		.mode     (r.mode),
		.hiByte   (r.hiByte),
		.loByte   (memRdata),
		.index    ({r.idxHi, r.idxLo}),
		.stackPtr (r.sp),
		.addr     (opAddr)
	);

	// Helper values shared by several states.
	assign pcInc   = r.pc + 16'h0001;
	assign vecBase = r.vecIrq ? IRQ_VECTOR : TRAP_VECTOR;
	assign cpuIdle = (r.st == ST_HALT);

	// Read multiplexer of the register port; unmapped offsets read as zero.
	always_comb begin
		case (address)
			REG_CTRL:   regValue = {31'h0000_0000, r.run};
			REG_STATUS: regValue = {30'h0000_0000, r.st == ST_WAIT, cpuIdle};
			REG_ACC:    regValue = {24'h00_0000, r.acc};
			REG_INDEX:  regValue = {16'h0000, r.idxHi, r.idxLo};
			REG_STACK:  regValue = {16'h0000, r.sp};
			REG_FLAGS:  regValue = {24'h00_0000, r.flg};
			REG_PCNT:   regValue = {16'h0000, r.pc};
			default:    regValue = 32'h0000_0000;
		endcase
	end

	// ****************************************************************
	// Next-state logic
	// ****************************************************************

	// Each state is one bus cycle; the address for the next cycle is set in the current one.
	always_comb begin
		next_r = r;
		case (r.st)
			ST_HALT: begin
				next_r.mem.addr = r.pc;
				next_r.mem.rd = 1'b0;
				if (r.run) begin
					next_r.mem.rd = 1'b1;
					next_r.st = ST_FETCH;
				end
			end
			ST_FETCH: begin
				next_r.pc = pcInc;
				next_r.mem.addr = pcInc;
				next_r.mem.rd = 1'b1;
				if (!r.run) begin
					next_r.pc = r.pc;
					next_r.mem.addr = r.pc;
					next_r.mem.rd = 1'b0;
					next_r.st = ST_HALT;
				end else if (irqReq && !r.flg[FLAG_I]) begin
					// The fetched opcode is dropped and runs again after the handler.
					next_r.pc = r.pc;
					next_r.vecIrq = 1'b1;
					next_r.mem.rd = 1'b0;
					next_r.st = ST_TRAP;
				end else begin
					case (memRdata)
						OP_SZC_ACC: begin
							next_r.flg = testFlags(r.flg, r.acc); // RULE4
						end
						OP_SZC_IDX: begin
							next_r.flg = testFlags(r.flg, r.idxLo); // RULE4
						end
						OP_SZC_DIR: begin
							next_r.mode = MODE_DIR; // RULE8
							next_r.st = ST_BYTE1;
						end
						OP_SZC_XB: begin
							next_r.mode = MODE_XB; // RULE6
							next_r.st = ST_BYTE1;
						end
						OP_SZC_ABS: begin
							next_r.mode = MODE_ABS; // RULE9
							next_r.st = ST_BYTE1;
						end
						OP_SZC_XW: begin
							next_r.mode = MODE_XW; // RULE10
							next_r.st = ST_BYTE1;
						end
						OP_SZC_XP: begin
							next_r.mem.addr = {r.idxHi, r.idxLo}; // RULE7
							next_r.st = ST_OPND;
						end
						OP_PREFIX: begin
							next_r.st = ST_PREFIX;
						end
						OP_TRAP: begin
							next_r.vecIrq = 1'b0; // RULE1
							next_r.mem.rd = 1'b0;
							next_r.st = ST_TRAP;
						end
						OP_WAIT: begin
							next_r.flg[FLAG_I] = 1'b0; // RULE2
							next_r.mem.rd = 1'b0;
							next_r.clockStop = 1'b1; // RULE3
							next_r.st = ST_WAIT;
						end
						OP_ACC_TO_FLAGS: begin
							next_r.flg = r.acc | FLAG_FIXED; // RULE11
							next_r.mem.rd = 1'b0;
							next_r.st = ST_EXEC2;
						end
						OP_FLAGS_TO_ACC: begin
							next_r.acc = r.flg; // RULE11
						end
						OP_ACC_TO_INDEX: begin
							next_r.idxLo = r.acc; // RULE11
						end
						OP_INDEX_TO_ACC: begin
							next_r.acc = r.idxLo; // RULE11
						end
						OP_SP_TO_INDEX: begin
							{next_r.idxHi, next_r.idxLo} = r.sp + 16'h0001; // RULE12
							next_r.mem.rd = 1'b0;
							next_r.st = ST_EXEC2;
						end
						OP_INDEX_TO_SP: begin
							next_r.sp = {r.idxHi, r.idxLo} - 16'h0001; // RULE12
							next_r.mem.rd = 1'b0;
							next_r.st = ST_EXEC2;
						end
						default: begin
						end
					endcase
				end
			end
			ST_PREFIX: begin
				// Only the stack-offset test is served after the prefix; others are skipped.
				next_r.pc = pcInc;
				next_r.mem.addr = pcInc;
				next_r.st = ST_FETCH;
				if (memRdata == OP_SZC_SB_LO) begin
					next_r.mode = MODE_SB; // RULE5
					next_r.st = ST_BYTE1;
				end
			end
			ST_BYTE1: begin
				next_r.pc = pcInc;
				next_r.hiByte = memRdata;
				if (r.mode == MODE_ABS || r.mode == MODE_XW) begin
					next_r.mem.addr = pcInc; // RULE9 RULE10
					next_r.st = ST_BYTE2;
				end else begin
					next_r.mem.addr = opAddr; // RULE5 RULE6 RULE8
					next_r.st = ST_OPND;
				end
			end
			ST_BYTE2: begin
				next_r.pc = pcInc;
				next_r.mem.addr = opAddr; // RULE9 RULE10
				next_r.st = ST_OPND;
			end
			ST_OPND: begin
				next_r.flg = testFlags(r.flg, memRdata); // RULE4
				next_r.mem.addr = r.pc;
				next_r.st = ST_FETCH;
			end
			ST_EXEC2: begin
				next_r.mem.rd = 1'b1;
				next_r.st = ST_FETCH;
			end
			ST_TRAP: begin
				next_r.mem.addr = r.sp;
				next_r.mem.wr = 1'b1;
				next_r.mem.wdata = pushByte(3'h0, r.pc, r.idxLo, r.acc, r.flg); // RULE1
				next_r.pushIdx = 3'h0;
				next_r.st = ST_PUSH;
			end
			ST_PUSH: begin
				next_r.sp = r.sp - 16'h0001; // RULE1
				next_r.pushIdx = r.pushIdx + 3'h1;
				if (r.pushIdx == PUSH_LAST) begin
					next_r.mem.wr = 1'b0;
					next_r.flg[FLAG_I] = 1'b1; // RULE1
					next_r.mem.rd = 1'b1;
					next_r.mem.addr = vecBase;
					next_r.st = ST_VECHI;
				end else begin
					next_r.mem.addr = r.sp - 16'h0001;
					next_r.mem.wdata = pushByte(r.pushIdx + 3'h1, r.pc, r.idxLo, r.acc, r.flg);
				end
			end
			ST_VECHI: begin
				next_r.hiByte = memRdata;
				next_r.mem.addr = vecBase + 16'h0001;
				next_r.st = ST_VECLO;
			end
			ST_VECLO: begin
				next_r.pc = {r.hiByte, memRdata}; // RULE1
				next_r.mem.addr = {r.hiByte, memRdata};
				next_r.st = ST_FETCH;
			end
			ST_WAIT: begin
				// Frozen until an interrupt wakes the core into the stacking entry.
				if (irqReq) begin
					next_r.clockStop = 1'b0; // RULE3
					next_r.vecIrq = 1'b1;
					next_r.st = ST_TRAP;
				end
			end
			default: begin
				next_r.st = ST_HALT;
			end
		endcase

		// Bus slave: accept with waitrequest high, answer one cycle later, then recover.
		if (r.waitReq && (read || write)) begin
			next_r.waitReq = 1'b0;
			if (read) begin
				next_r.readData = regValue;
			end
		end else if (!r.waitReq) begin
			next_r.waitReq = 1'b1;
			if (write) begin
				if (address == REG_CTRL && byteenable[0]) begin
					next_r.run = writedata[CTRL_RUN];
				end
				// Core registers take writes only while the core is halted with the run bit clear.
				if (cpuIdle && !r.run) begin
					case (address)
						REG_ACC: begin
							if (byteenable[0]) begin
								next_r.acc = writedata[7:0];
							end
						end
						REG_INDEX: begin
							{next_r.idxHi, next_r.idxLo} =
								merge16({r.idxHi, r.idxLo}, writedata, byteenable);
						end
						REG_STACK: begin
							next_r.sp = merge16(r.sp, writedata, byteenable);
						end
						REG_FLAGS: begin
							if (byteenable[0]) begin
								next_r.flg = writedata[7:0] | FLAG_FIXED;
							end
						end
						REG_PCNT: begin
							next_r.pc = merge16(r.pc, writedata, byteenable);
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************

	// All state advances only while the clock enable is high.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			r.st <= ST_HALT;
			r.mode <= MODE_DIR;
			r.pc <= RESET_PC;
			r.sp <= RESET_SP;
			r.acc <= 8'h00;
			r.idxHi <= 8'h00;
			r.idxLo <= 8'h00;
			r.flg <= FLAG_RESET;
			r.hiByte <= 8'h00;
			r.pushIdx <= 3'h0;
			r.vecIrq <= 1'b0;
			r.run <= 1'b0;
			r.clockStop <= 1'b0;
			r.mem <= '0;
			r.waitReq <= 1'b1;
			r.readData <= 32'h0000_0000;
		end else if (ce) begin
			r <= next_r;
		end
	end

	// Outputs come straight from the state register.
	assign memAddr     = r.mem.addr;
	assign memWdata    = r.mem.wdata;
	assign memRead     = r.mem.rd;
	assign memWrite    = r.mem.wr;
	assign clockStop   = r.clockStop;
	assign readdata    = r.readData;
	assign waitrequest = r.waitReq;

endmodule

// ### hdl/cts_pkg.sv
// Package of constants, types and state encodings for the transfer, test, trap and wait core.
//
// Notes on behaviour
// RULE1: The software trap (0x83) takes 9 cycles, advances the counter, pushes counter low, counter high, index low, accumulator and flags with a decrement each, sets the mask and loads the vector.
// RULE2: The wait instruction (0x8F) takes 1 cycle, clears the interrupt mask and leaves every other flag alone.
// RULE3: After wait the core freezes its own logic until an interrupt arrives and then resumes through the normal interrupt entry.
// RULE4: The test instruction compares the accumulator (0x4D), index low byte (0x5D) or a memory byte against zero, sets negative and zero, clears overflow, keeps the rest and writes no register.
// RULE5: The stack-offset test (0x9E 0x6D plus one byte) takes 4 cycles and reads from the stack pointer plus the unsigned offset.
// RULE6: The byte-offset indexed test (0x6D) takes 3 cycles and reads from the index register plus the offset byte.
// RULE7: The plain indexed test (0x7D) takes 2 cycles and reads from the index register itself.
// RULE8: The direct test (0x3D) takes 3 cycles and reads from the direct address given by the byte after the opcode.
// RULE9: Extended addressing takes the next two bytes, high first, as the full operand address.
// RULE10: Word-offset indexed addressing takes a high then low offset byte and adds them to the index register.
// RULE11: Accumulator-to-flags takes 2 cycles and may change every flag, while flags-to-accumulator and the accumulator/index transfers take 1 cycle and change no flag.
// RULE12: Stack-pointer-to-index loads the pointer plus one, index-to-stack-pointer loads the index minus one, each in 2 cycles with no flag change.
package cts_pkg;

	// ****************************************************************
	// Opcodes
	// ****************************************************************
	localparam logic [7:0] OP_SZC_DIR       = 8'h3D;
	localparam logic [7:0] OP_SZC_ACC       = 8'h4D;
	localparam logic [7:0] OP_SZC_IDX       = 8'h5D;
	localparam logic [7:0] OP_SZC_XB        = 8'h6D;
	localparam logic [7:0] OP_SZC_XP        = 8'h7D;
	localparam logic [7:0] OP_SZC_ABS       = 8'hCD;
	localparam logic [7:0] OP_SZC_XW        = 8'hDD;
	localparam logic [7:0] OP_PREFIX        = 8'h9E;
	localparam logic [7:0] OP_SZC_SB_LO     = 8'h6D;
	localparam logic [7:0] OP_TRAP          = 8'h83;
	localparam logic [7:0] OP_WAIT          = 8'h8F;
	localparam logic [7:0] OP_ACC_TO_FLAGS  = 8'h84;
	localparam logic [7:0] OP_FLAGS_TO_ACC  = 8'h85;
	localparam logic [7:0] OP_ACC_TO_INDEX  = 8'h97;
	localparam logic [7:0] OP_INDEX_TO_ACC  = 8'h9F;
	localparam logic [7:0] OP_SP_TO_INDEX   = 8'h95;
	localparam logic [7:0] OP_INDEX_TO_SP   = 8'h94;

	// ****************************************************************
	// Flag register layout and reset values
	// ****************************************************************
	localparam int         FLAG_V         = 7;
	localparam int         FLAG_I         = 3;
	localparam int         FLAG_N         = 2;
	localparam int         FLAG_Z         = 1;
	localparam logic [7:0] FLAG_FIXED     = 8'h60;
	localparam logic [7:0] FLAG_RESET     = 8'h68;
	localparam logic [2:0] PUSH_LAST      = 3'h4;

	// ****************************************************************
	// Register map, byte addresses
	// ****************************************************************
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_STATUS     = 8'h04;
	localparam logic [7:0] REG_ACC        = 8'h08;
	localparam logic [7:0] REG_INDEX      = 8'h0C;
	localparam logic [7:0] REG_STACK      = 8'h10;
	localparam logic [7:0] REG_FLAGS      = 8'h14;
	localparam logic [7:0] REG_PCNT       = 8'h18;
	localparam int         CTRL_RUN       = 0;
	localparam int         STAT_HALTED    = 0;
	localparam int         STAT_WAITING   = 1;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {
		MODE_DIR, MODE_ABS, MODE_XP, MODE_XB, MODE_XW, MODE_SB
	} cts_mode_type;

	typedef enum logic [3:0] {
		ST_HALT, ST_FETCH, ST_PREFIX, ST_BYTE1, ST_BYTE2, ST_OPND, ST_EXEC2,
		ST_TRAP, ST_PUSH, ST_VECHI, ST_VECLO, ST_WAIT
	} cts_state_type;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        rd;
		logic        wr;
	} cts_mem_type;

	typedef struct packed {
		cts_state_type st;
		cts_mode_type  mode;
		logic [15:0]   pc;
		logic [15:0]   sp;
		logic [7:0]    acc;
		logic [7:0]    idxHi;
		logic [7:0]    idxLo;
		logic [7:0]    flg;
		logic [7:0]    hiByte;
		logic [2:0]    pushIdx;
		logic          vecIrq;
		logic          run;
		logic          clockStop;
		cts_mem_type   mem;
		logic          waitReq;
		logic [31:0]   readData;
	} cts_core_type;

endpackage

// ### verification/cts_core_checker.sv
// Checker of bus handshake, stacking, vector fetch and wait parking at the core ports.
`timescale 1ns/1ps

module cts_core_checker
	import cts_pkg::*;
#(
	parameter logic [15:0] TRAP_VECTOR = 16'hFFF0,
	parameter logic [15:0] IRQ_VECTOR  = 16'hFFF2
)
(
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        ce,
	input wire logic        irqReq,
	input wire logic [7:0]  memRdata,
	input wire logic [15:0] memAddr,
	input wire logic        memRead,
	input wire logic        memWrite,
	input wire logic        clockStop,
	input wire logic        read,
	input wire logic        write,
	input wire logic        waitrequest
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// ****************************************************************
	// Sequences
	// ****************************************************************
	// Four further pushes, each one byte lower, then the writes stop.
	sequence s_push_run;
		(memWrite && memAddr == $past(memAddr) - 16'h0001) [*4] ##1 !memWrite;
	endsequence
	// Vector high byte then low byte at the next address.
	sequence s_vec_pair;
		memRead && (memAddr == TRAP_VECTOR || memAddr == IRQ_VECTOR)
			##1 (memRead && memAddr == $past(memAddr) + 16'h0001);
	endsequence

	// ****************************************************************
	// Properties
	// ****************************************************************
	property p_ack;
		ce && (read || write) && waitrequest |=> !waitrequest;
	endproperty
	property p_ack_one;
		!waitrequest |=> waitrequest;
	endproperty
	property p_excl;
		!(memRead && memWrite);
	endproperty
	property p_push;
		memWrite && !$past(memWrite) |=> s_push_run;
	endproperty
	property p_vec;
		$fell(memWrite) |-> s_vec_pair;
	endproperty
	property p_wait_cause;
		$rose(clockStop) |-> $past(memRead) && $past(memRdata) == OP_WAIT;
	endproperty
	property p_park_quiet;
		clockStop && !irqReq |-> !memRead && !memWrite;
	endproperty
	property p_park_hold;
		clockStop && !irqReq |=> clockStop;
	endproperty
	property p_wake;
		$fell(clockStop) |-> $past(irqReq) ##[0:3] memWrite;
	endproperty

	a_ack: assert property (p_ack) else $error("bus request not answered in one cycle");
	a_ack_one: assert property (p_ack_one) else $error("bus answer held too long");
	a_excl: assert property (p_excl) else $error("read and write strobes together");
	a_push: assert property (p_push) else $error("push run wrong");
	a_vec: assert property (p_vec) else $error("vector fetch wrong");
	a_wait_cause: assert property (p_wait_cause) else $error("park without wait");
	a_park_quiet: assert property (p_park_quiet) else $error("access while parked");
	a_park_hold: assert property (p_park_hold) else $error("parking left early");
	a_wake: assert property (p_wake) else $error("wake without stacking");
	c_trap: cover property (memWrite && memAddr != 16'h0000);
endmodule

bind cts_core cts_core_checker #(.TRAP_VECTOR(TRAP_VECTOR), .IRQ_VECTOR(IRQ_VECTOR)) u_chk (
	.mclk(mclk), .rst(rst), .ce(ce), .irqReq(irqReq), .memRdata(memRdata),
	.memAddr(memAddr), .memRead(memRead), .memWrite(memWrite), .clockStop(clockStop),
	.read(read), .write(write), .waitrequest(waitrequest));

// ### verification/cts_mem_model.sv
// Program and data memory model answering the core in the same cycle.
`timescale 1ns/1ps

module cts_mem_model
(
	input  wire logic        mclk,
	input  wire logic [15:0] memAddr,
	input  wire logic [7:0]  memWdata,
	input  wire logic        memRead,
	input  wire logic        memWrite,
	output logic [7:0]       memRdata
);
	logic [7:0] arr [0:65535];
	logic [7:0] lastRd;

	// Read data only while the strobe is up, otherwise the inverse of the last read.
	assign memRdata = memRead ? arr[memAddr] : ~lastRd;

	// Writes land on the edge that ends the write cycle.
	always @(posedge mclk) begin
		if (memRead === 1'b1) begin
			lastRd <= arr[memAddr];
		end
		if (memWrite === 1'b1) begin
			arr[memAddr] <= memWdata;
		end
	end
endmodule

// ### verification/tb.sv
// Self-checking bench of the core: test, transfer, trap and wait cases against a queue model.
`timescale 1ns/1ps

module tb
	import cts_pkg::*;
;
	logic        mclk, rst, ce, irqReq, memRead, memWrite, clockStop;
	logic [7:0]  memRdata, memWdata, address;
	logic [15:0] memAddr, startPc, stopPc;
	logic        read, write, waitrequest;
	logic [31:0] writedata, readdata;
	logic [3:0]  byteenable;
	int          err_total, comparisons, cyc, tStart, tEnd;
	logic [23:0] gotQ[$], expQ[$];
	// The last opcode is one the core does not decode, so it must act as a one-cycle no-op.
	logic [7:0]  opTab [16] = '{OP_SZC_DIR, OP_SZC_ACC, OP_SZC_IDX, OP_SZC_XB, OP_SZC_XP,
		OP_SZC_ABS, OP_SZC_XW, OP_PREFIX, OP_ACC_TO_FLAGS, OP_FLAGS_TO_ACC, OP_ACC_TO_INDEX,
		OP_INDEX_TO_ACC, OP_SP_TO_INDEX, OP_INDEX_TO_SP, OP_TRAP, 8'h9D};
	int          lenTab [16] = '{2, 1, 1, 2, 1, 3, 3, 3, 1, 1, 1, 1, 1, 1, 1, 1};
	int          cycTab [16] = '{3, 1, 1, 3, 2, 4, 4, 4, 2, 1, 1, 1, 2, 2, 9, 1};

	cts_core DUT (.mclk(mclk), .rst(rst), .ce(ce), .irqReq(irqReq), .memRdata(memRdata),
		.memAddr(memAddr), .memWdata(memWdata), .memRead(memRead), .memWrite(memWrite),
		.clockStop(clockStop), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest));
	cts_mem_model MEM (.mclk(mclk), .memAddr(memAddr), .memWdata(memWdata),
		.memRead(memRead), .memWrite(memWrite), .memRdata(memRdata));

	// ****************************************************************
	// Clock, monitor and closing
	// ****************************************************************
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// Records instruction boundaries and every memory write.
	always @(posedge mclk) begin
		cyc++;
		if (memRead === 1'b1 && memAddr === startPc && tStart < 0) tStart = cyc;
		if (memRead === 1'b1 && memAddr === stopPc && tStart >= 0 && tEnd < 0) tEnd = cyc;
		if (memWrite === 1'b1) gotQ.push_back({memAddr, memWdata});
	end

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_cnt(input int got, input int exp);
		chk_val(32'(got), 32'(exp));
	endtask

	// One Avalon transfer held until waitrequest is seen low, then one idle edge.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		address <= a;
		writedata <= d;
		byteenable <= 4'hF;
		read <= !wr;
		write <= wr;
		@(posedge mclk);
		while (waitrequest !== 1'b0 && n < 50) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 50) err_total++;
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] a, input int d);
		logic [31:0] q;
		bus(1'b1, a, 32'(d), q);
	endtask

	// Expected five-byte stacking frame.
	task automatic push5(input int s, input int pc, input int x, input int av, input int fv);
		expQ.push_back({16'(s), 8'(pc)});
		expQ.push_back({16'(s - 1), 8'(pc >> 8)});
		expQ.push_back({16'(s - 2), 8'(x)});
		expQ.push_back({16'(s - 3), 8'(av)});
		expQ.push_back({16'(s - 4), 8'(fv)});
	endtask

	// ****************************************************************
	// One instruction, then wait, then interrupt entry
	// ****************************************************************
	task automatic run_case(input int i, input int rep);
		logic [31:0] q;
		logic [7:0]  op;
		int          a, hx, sp, f, b1, b2, m, ea, ra, rhx, rsp, rf, ret, n;
		op = opTab[i];
		a = $urandom & 'hFF;
		hx = 'h2000 + ($urandom & 'h1FFF);
		sp = 'h80 + ($urandom & 'h7F);
		f = ($urandom & 'h9F) | 'h60;
		b1 = 'h20 | ($urandom & 'h1F);
		b2 = $urandom & 'hFF;
		m = (rep == 0) ? 0 : (rep == 1) ? 'h80 : ($urandom & 'hFF);
		ea = -1;
		case (op)
			OP_SZC_DIR: ea = b1;
			OP_SZC_XB: ea = (hx + b1) & 'hFFFF;
			OP_SZC_XP: ea = hx;
			OP_SZC_ABS: ea = (b1 << 8) | b2;
			OP_SZC_XW: ea = (hx + ((b1 << 8) | b2)) & 'hFFFF;
			OP_PREFIX: ea = sp + b2;
			OP_SZC_ACC: a = m;
			OP_SZC_IDX: hx = (hx & 'hFF00) | m;
			default: ea = -1;
		endcase
		MEM.arr[16'h0401] = (op == OP_PREFIX) ? OP_SZC_SB_LO : 8'(b1);
		MEM.arr[16'h0402] = 8'(b2);
		MEM.arr[16'h0400] = op;
		MEM.arr[16'(16'h0400 + lenTab[i])] = OP_WAIT;
		if (ea >= 0) MEM.arr[16'(ea)] = 8'(m);
		ra = a;
		rhx = hx;
		rsp = sp;
		rf = f;
		ret = 'h401 + lenTab[i];
		expQ.delete();
		case (op)
			OP_ACC_TO_FLAGS: rf = a | 'h60;
			OP_FLAGS_TO_ACC: ra = f;
			OP_ACC_TO_INDEX: rhx = (hx & 'hFF00) | a;
			OP_INDEX_TO_ACC: ra = hx & 'hFF;
			OP_SP_TO_INDEX: rhx = sp + 1;
			OP_INDEX_TO_SP: rsp = hx - 1;
			OP_TRAP: rsp = sp - 5;
			8'h9D: rf = f;
			default: rf = (f & 'h79) | ((m >> 5) & 4) | ((m == 0) ? 2 : 0);
		endcase
		if (op == OP_TRAP) push5(sp, 'h401, hx, a, f);
		if (op == OP_TRAP) ret = 'h601;
		rf = rf & 'hF7;
		push5(rsp, ret, rhx, ra, rf);
		wr(REG_ACC, a);
		wr(REG_INDEX, hx);
		wr(REG_STACK, sp);
		wr(REG_FLAGS, f);
		wr(REG_PCNT, 'h400);
		gotQ.delete();
		tStart = -1;
		tEnd = -1;
		startPc = 16'h0400;
		stopPc = (op == OP_TRAP) ? 16'h0600 : 16'(16'h0400 + lenTab[i]);
		wr(REG_CTRL, 1);
		for (n = 0; n < 200 && clockStop !== 1'b1; n++) @(posedge mclk);
		bus(1'b0, REG_ACC, 0, q);
		chk_val(q, 32'(ra));
		bus(1'b0, REG_INDEX, 0, q);
		chk_val(q, 32'(rhx & 'hFFFF));
		bus(1'b0, REG_STACK, 0, q);
		chk_val(q, 32'(rsp & 'hFFFF));
		bus(1'b0, REG_FLAGS, 0, q);
		chk_val(q, 32'(rf));
		bus(1'b0, REG_STATUS, 0, q);
		chk_val({31'h0000_0000, q[STAT_WAITING]}, 32'h0000_0001);
		chk_cnt(tEnd - tStart, cycTab[i]);
		wr(REG_CTRL, 0);
		irqReq <= 1'b1;
		for (n = 0; n < 200 && clockStop !== 1'b0; n++) @(posedge mclk);
		irqReq <= 1'b0;
		q = 32'h0000_0000;
		for (n = 0; n < 50 && q[STAT_HALTED] !== 1'b1; n++) bus(1'b0, REG_STATUS, 0, q);
		chk_cnt(gotQ.size(), expQ.size());
		foreach (expQ[k]) chk_val({8'h00, gotQ[k]}, {8'h00, expQ[k]});
		$display("case opcode %h pass %0d done", op, rep);
	endtask

	// ****************************************************************
	// Main sequence and watchdog
	// ****************************************************************
	initial begin
		logic [31:0] q;
		rst = 1'b1;
		ce = 1'b1;
		irqReq = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 8'h00;
		writedata = 32'h0000_0000;
		byteenable = 4'h0;
		err_total = 0;
		comparisons = 0;
		cyc = 0;
		tStart = -1;
		tEnd = -1;
		startPc = 16'h0000;
		stopPc = 16'h0000;
		void'($urandom(25));
		MEM.arr[16'hFFF0] = 8'h06;
		MEM.arr[16'hFFF1] = 8'h00;
		MEM.arr[16'hFFF2] = 8'h07;
		MEM.arr[16'hFFF3] = 8'h00;
		MEM.arr[16'h0600] = OP_WAIT;
		MEM.arr[16'h0700] = OP_WAIT;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		bus(1'b0, REG_FLAGS, 0, q);
		chk_val(q, 32'(FLAG_RESET));
		bus(1'b0, REG_STACK, 0, q);
		chk_val(q, 32'h0000_00FF);
		bus(1'b0, 8'h40, 0, q);
		chk_val(q, 32'h0000_0000);
		for (int rep = 0; rep < 3; rep++) begin
			for (int i = 0; i < 16; i++) begin
				run_case(i, rep);
			end
		end
		tally_and_finish;
	end

	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (40000) @(posedge mclk);
		err_total++;
		tally_and_finish;
	end
endmodule
